/* File: logic/sram_access.sv */
// Purpose: Access control, burst counting and array of a flow-through burst SRAM
// Assumes: Pins are synchronous to I_SYS_CLK; the data pins are split into in, out, enable
// Notes: Writes pass a two-entry buffer before the array; reads see buffered data
`timescale 1ns/1ps

module sram_access (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // Synchronous control
  input wire logic I_CLOCK_GATE_N,
  input wire logic I_CHIP_SELECT_A_N,
  input wire logic I_CHIP_SELECT_B,
  input wire logic I_CHIP_SELECT_C_N,
  input wire logic I_ADVANCE_LOAD_N,
  input wire logic I_WRITE_STROBE_N,
  input wire logic [3:0] I_BYTE_LANE_WRITE_N,
  input wire logic I_OUTPUT_DRIVE_EN_N,
  input wire logic I_BURST_ORDER,
  input wire logic [19:0] I_ADDR,
  // Data pins, input side
  input wire logic [31:0] I_DQ,
  input wire logic [3:0] I_PARITY_PINS,
  // Data pins, output side
  output logic [31:0] O_DQ,
  output logic [3:0] O_PARITY_PINS,
  output logic O_DQ_OE,
  // Write buffer room, for the controller to hold back writes
  output logic O_WBUF_READY
);

  // Storage
  logic [sram_access_pkg::WORD_W-1:0] mem [sram_access_pkg::DEPTH];
  sram_access_pkg::wr_entry_type wbuf [sram_access_pkg::WBUF_DEPTH];

  // Access state
  sram_access_pkg::cycle_type cyc_q, cyc_d;
  logic [sram_access_pkg::ADDR_W-1:0] base_q, base_d;
  logic [sram_access_pkg::BEAT_W-1:0] beat_q, beat_d;
  logic order_q, order_d;
  logic [sram_access_pkg::ADDR_W-1:0] acc_q, acc_d;
  sram_access_pkg::wr_cmd_type pend_q, pend_d;

  // Buffer state
  logic [1:0] cnt_q, cnt_d;
  logic head_q, head_d;

  // Output state
  logic [sram_access_pkg::WORD_W-1:0] word_q, word_d;
  logic oe_q, oe_d;
  logic wready_q, wready_d;

  // Folds the pins into lanes of eight data bits plus one parity bit
  function automatic logic [sram_access_pkg::WORD_W-1:0] pins_to_word(
    input logic [31:0] dq,
    input logic [3:0] par
  );
    logic [sram_access_pkg::WORD_W-1:0] w;
    w = sram_access_pkg::WORD_RST;
    for (int k = 0; k < sram_access_pkg::LANES; k++) begin
      w[k*sram_access_pkg::LANE_W + sram_access_pkg::LANE_DATA_LSB +: 8] = dq[k*8 +: 8];
      w[k*sram_access_pkg::LANE_W + sram_access_pkg::LANE_PAR_BIT] = par[k];
    end
    return w;
  endfunction : pins_to_word

  // Overlays the enabled lanes of a pending write onto a word when addresses match
  function automatic logic [sram_access_pkg::WORD_W-1:0] overlay(
    input logic [sram_access_pkg::WORD_W-1:0] word,
    input sram_access_pkg::wr_entry_type e,
    input logic live,
    input logic [sram_access_pkg::ADDR_W-1:0] addr
  );
    logic [sram_access_pkg::WORD_W-1:0] w;
    w = word;
    for (int k = 0; k < sram_access_pkg::LANES; k++) begin
      if (live && e.addr == addr && !e.lane_n[k]) begin
        w[k*sram_access_pkg::LANE_W +: sram_access_pkg::LANE_W] =
          e.data[k*sram_access_pkg::LANE_W +: sram_access_pkg::LANE_W];
      end
    end
    return w;
  endfunction : overlay

  // Edge qualification and cycle decode
  wire en = ~I_CLOCK_GATE_N;
  wire selected = ~I_CHIP_SELECT_A_N & I_CHIP_SELECT_B & ~I_CHIP_SELECT_C_N;
  wire do_load = en & ~I_ADVANCE_LOAD_N;
  wire start = do_load & selected;
  wire desel = do_load & ~selected;
  // A deselected device only leaves that state on a load, so advance needs a live burst
  wire advance = en & I_ADVANCE_LOAD_N & (cyc_q != sram_access_pkg::CYC_DESELECT);
  wire beat_edge = start | advance;

  // Next access state; with the gate high every term falls back to its own register
  assign cyc_d = start ? (I_WRITE_STROBE_N ? sram_access_pkg::CYC_READ :
                                             sram_access_pkg::CYC_WRITE) :
                 desel ? sram_access_pkg::CYC_DESELECT : cyc_q;
  assign base_d = start ? I_ADDR : base_q;
  assign beat_d = start ? sram_access_pkg::BEAT_RST :
                  advance ? beat_q + 2'h1 : beat_q;
  assign order_d = start ? I_BURST_ORDER : order_q;

  // Burst address: only the low two bits move, in the strapped order
  wire [1:0] low_lin = base_d[1:0] + beat_d;
  wire [1:0] low_ilv = base_d[1:0] ^ beat_d;
  wire [1:0] low_d = (order_d == sram_access_pkg::ORDER_INTERLEAVED) ? low_ilv : low_lin;
  assign acc_d = {base_d[sram_access_pkg::ADDR_W-1:2], low_d};

  // Beat kinds starting at this edge
  wire rd_now = beat_edge & (cyc_d == sram_access_pkg::CYC_READ);
  wire wr_now = beat_edge & (cyc_d == sram_access_pkg::CYC_WRITE);

  // Write command waits one enabled edge for its data
  assign pend_d = en ? '{valid: wr_now, addr: acc_d, lane_n: I_BYTE_LANE_WRITE_N} :
                       pend_q;

  // Buffer fill side: the data edge of a write
  wire push_valid = en & pend_q.valid;
  wire push_ready = (cnt_q != sram_access_pkg::WBUF_FULL);
  wire push = push_valid & push_ready;
  sram_access_pkg::wr_entry_type push_entry;
  assign push_entry = '{addr: pend_q.addr, lane_n: pend_q.lane_n,
                        data: pins_to_word(I_DQ, I_PARITY_PINS)};

  // Buffer drain side: the single array port goes to a read first, so drains stall;
  // a suspended edge holds the buffer as well, so only the drive enable register moves while gated
  wire pop_valid = (cnt_q != 2'h0);
  wire pop_ready = en & ~rd_now;
  wire pop = pop_valid & pop_ready;
  wire tail = head_q ^ cnt_q[0];
  assign cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};
  assign head_d = head_q ^ pop;
  assign wready_d = (cnt_d != sram_access_pkg::WBUF_FULL);

  // Read path: array word with buffered and just-captured writes laid over it, oldest first
  wire [sram_access_pkg::WORD_W-1:0] rd_raw = mem[acc_d];
  wire [sram_access_pkg::WORD_W-1:0] rd_m0 = overlay(rd_raw, wbuf[head_q],
                                                     cnt_q != 2'h0, acc_d);
  wire [sram_access_pkg::WORD_W-1:0] rd_m1 = overlay(rd_m0, wbuf[~head_q],
                                                     cnt_q == sram_access_pkg::WBUF_FULL, acc_d);
  wire [sram_access_pkg::WORD_W-1:0] rd_word = overlay(rd_m1, push_entry, push, acc_d);

  // Flow-through: data is registered on the edge that takes the address
  assign word_d = rd_now ? rd_word : word_q;
  // Drive only in read cycles with drive enable low, gated edges included; write and deselect float
  assign oe_d = (cyc_d == sram_access_pkg::CYC_READ) & ~I_OUTPUT_DRIVE_EN_N;

  // Access control registers; inputs are taken only at the rising edge
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cyc_q <= sram_access_pkg::CYC_DESELECT;
      base_q <= sram_access_pkg::ADDR_RST;
      beat_q <= sram_access_pkg::BEAT_RST;
      order_q <= sram_access_pkg::ORDER_LINEAR;
      acc_q <= sram_access_pkg::ADDR_RST;
      pend_q <= '{valid: 1'h0, addr: sram_access_pkg::ADDR_RST,
                  lane_n: sram_access_pkg::LANE_N_RST};
    end else begin
      cyc_q <= cyc_d;
      base_q <= base_d;
      beat_q <= beat_d;
      order_q <= order_d;
      acc_q <= acc_d;
      pend_q <= pend_d;
    end
  end

  // Buffer pointers and pin-facing outputs
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cnt_q <= sram_access_pkg::CNT_RST;
      head_q <= 1'h0;
      word_q <= sram_access_pkg::WORD_RST;
      oe_q <= sram_access_pkg::OE_RST;
      wready_q <= sram_access_pkg::WBUF_READY_RST;
    end else begin
      cnt_q <= cnt_d;
      head_q <= head_d;
      word_q <= word_d;
      oe_q <= oe_d;
      wready_q <= wready_d;
    end
  end

  // Data storage has no reset: contents are undefined until written
  always_ff @(posedge I_SYS_CLK) begin
    if (push) begin
      wbuf[tail] <= push_entry;
    end
    if (pop) begin
      for (int k = 0; k < sram_access_pkg::LANES; k++) begin
        if (!wbuf[head_q].lane_n[k]) begin
          mem[wbuf[head_q].addr][k*sram_access_pkg::LANE_W +: sram_access_pkg::LANE_W] <=
            wbuf[head_q].data[k*sram_access_pkg::LANE_W +: sram_access_pkg::LANE_W];
        end
      end
    end
  end

  // Pins unpacked from the registered word
  always_comb begin
    for (int k = 0; k < sram_access_pkg::LANES; k++) begin
      O_DQ[k*8 +: 8] = word_q[k*sram_access_pkg::LANE_W + sram_access_pkg::LANE_DATA_LSB +: 8];
      O_PARITY_PINS[k] = word_q[k*sram_access_pkg::LANE_W + sram_access_pkg::LANE_PAR_BIT];
    end
  end
  assign O_DQ_OE = oe_q;
  assign O_WBUF_READY = wready_q;

  // Checks and coverage
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  localparam int ACC_LAT = sram_access_pkg::ACCESS_CYC;

  // Gate high freezes address, counter and direction
  a_gate_holds_state: assert property (
    I_CLOCK_GATE_N |=> $stable(base_q) && $stable(beat_q) && $stable(cyc_q) &&
                       $stable(pend_q) && $stable(word_q) && $stable(cnt_q))
    else $error("State moved while the clock gate was high");

  // Load with all selects captures the address bus
  a_load_takes_addr: assert property (
    start |=> base_q == $past(I_ADDR) && beat_q == 2'h0 && acc_q == $past(I_ADDR))
    else $error("Load edge did not capture the address");

  // Strobe level at start picks the direction
  a_dir_from_strobe: assert property (
    start |=> cyc_q == ($past(I_WRITE_STROBE_N) ? sram_access_pkg::CYC_READ :
                                                  sram_access_pkg::CYC_WRITE))
    else $error("Access direction does not follow the write strobe");

  // Write lanes come from the selects seen with the beat
  a_lane_select: assert property (
    wr_now |=> pend_q.valid && pend_q.lane_n == $past(I_BYTE_LANE_WRITE_N) &&
               pend_q.addr == acc_q)
    else $error("Write beat lost its lane selects or address");

  // Write data is taken at the very next enabled edge
  a_write_data_edge: assert property (
    (wr_now && wready_q) ##1 en |-> push)
    else $error("Write data not captured at the following edge");

  // Read with drive enable low drives within the access time
  a_read_flow: assert property (
    (rd_now && !I_OUTPUT_DRIVE_EN_N) |-> ##[1:ACC_LAT] O_DQ_OE)
    else $error("Read data not driven in its own cycle");

  // Driving only in read cycles with drive enable low
  a_drive_gate: assert property (
    O_DQ_OE |-> cyc_q == sram_access_pkg::CYC_READ && !$past(I_OUTPUT_DRIVE_EN_N))
    else $error("Pins driven outside a read with drive enable low");

  // Deselect on a load edge floats the pins at once
  a_deselect_float: assert property (
    desel |=> !O_DQ_OE [*1] ##0 cyc_q == sram_access_pkg::CYC_DESELECT)
    else $error("Deselect did not tri-state the outputs");

  // Advance keeps direction and upper address
  a_advance_keeps: assert property (
    advance |=> $stable(cyc_q) &&
                acc_q[sram_access_pkg::ADDR_W-1:2] == $past(acc_q[sram_access_pkg::ADDR_W-1:2]))
    else $error("Advance changed direction or upper address bits");

  // Linear order steps the low bits by one with wrap
  a_linear_step: assert property (
    (advance && order_q == sram_access_pkg::ORDER_LINEAR) |=>
      acc_q[1:0] == $past(acc_q[1:0]) + 2'h1)
    else $error("Linear burst step wrong");

  // Interleaved order toggles exactly the bits that the beat count toggles
  a_interleave_step: assert property (
    (advance && order_q == sram_access_pkg::ORDER_INTERLEAVED) |=>
      (acc_q[1:0] ^ $past(acc_q[1:0])) == (beat_q ^ $past(beat_q)))
    else $error("Interleaved burst step wrong");

  // Four advances bring the low bits back to the loaded start
  a_burst_wrap: assert property (
    (advance && beat_q == 2'h3) |=> acc_q[1:0] == base_q[1:0] && beat_q == 2'h0)
    else $error("Burst did not wrap to its start address");

  // Strap level at the load edge fixes the burst order
  a_order_from_strap: assert property (
    start |=> order_q == $past(I_BURST_ORDER))
    else $error("Burst order not taken from the strap");

  // An advance in a read burst is again a read beat, whatever the strobe shows
  a_advance_reads: assert property (
    (advance && cyc_q == sram_access_pkg::CYC_READ) |-> rd_now)
    else $error("Advance in a read burst lost its direction");

  // Read data stands until the next read beat
  a_read_holds_data: assert property (
    !rd_now |=> $stable(word_q))
    else $error("Read data changed without a read beat");

  // Write beats never drive the pins, whatever drive enable says
  a_write_floats: assert property (
    (cyc_q == sram_access_pkg::CYC_WRITE) |-> !O_DQ_OE)
    else $error("Pins driven during a write");

  // Advance while deselected neither starts an access nor drives
  a_desel_stays: assert property (
    (en && I_ADVANCE_LOAD_N && cyc_q == sram_access_pkg::CYC_DESELECT) |=>
      cyc_q == sram_access_pkg::CYC_DESELECT && !O_DQ_OE)
    else $error("Advance left the deselected state");

  // Write data at its data edge always finds a free entry, since write beats drain
  a_data_never_lost: assert property (
    (en && pend_q.valid) |-> push_ready)
    else $error("Write data dropped at a full buffer");

  // A full four-beat read burst
  c_read_burst: cover property (
    rd_now && start ##1 (rd_now && advance) [*3]);
  // Write immediately followed by a read
  c_write_then_read: cover property (wr_now && start ##1 rd_now && start);
  // Write buffer fills
  c_wbuf_full: cover property (cnt_q == sram_access_pkg::WBUF_FULL);
  // Gate stall in the middle of a burst
  c_gate_stall: cover property (advance ##1 I_CLOCK_GATE_N ##1 advance);
  // Advance shown while deselected
  c_desel_advance: cover property (desel ##1 (en && I_ADVANCE_LOAD_N));

endmodule : sram_access

/* File: logic/sram_access_pkg.sv */
// Purpose: Shared constants and types for the flow-through burst SRAM access logic
// Assumes: One 250 MHz clock, 36-bit word split into four 9-bit byte lanes
// Notes: Each lane holds eight data bits and one parity bit at its top
package sram_access_pkg;

  // Array and bus geometry
  localparam int ADDR_W = 20;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int LANE_DQ_W = 8;
  localparam int LANE_W = 9;
  localparam int WORD_W = 36;
  localparam int BEAT_W = 2;
  localparam int DEPTH = 1048576;

  // Field positions inside one 9-bit lane
  localparam int LANE_DATA_LSB = 0;
  localparam int LANE_PAR_BIT = 8;

  // Write buffer
  localparam int WBUF_DEPTH = 2;
  localparam logic [1:0] WBUF_FULL = 2'h2;

  // Burst order strap levels
  localparam logic ORDER_LINEAR = 1'h0;
  localparam logic ORDER_INTERLEAVED = 1'h1;

  // Timing: access delay from the clock rise, and the clock period
  localparam real T_ACCESS_NS = 6.5;
  localparam real CLK_PERIOD_NS = 4.0;
  // Longest time, rounded down, never below one cycle
  localparam int ACCESS_CYC = ($rtoi(T_ACCESS_NS / CLK_PERIOD_NS) < 1) ? 1 :
                              $rtoi(T_ACCESS_NS / CLK_PERIOD_NS);

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h000000000;
  localparam logic [LANES-1:0] LANE_N_RST = 4'hF;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic OE_RST = 1'h0;
  localparam logic WBUF_READY_RST = 1'h1;

  // What the current clock cycle is doing
  typedef enum logic [1:0] {CYC_DESELECT, CYC_READ, CYC_WRITE} cycle_type;

  // A write beat waiting for its data edge
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_n;
  } wr_cmd_type;

  // A complete write waiting to enter the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_n;
    logic [WORD_W-1:0] data;
  } wr_entry_type;

endpackage : sram_access_pkg

/* File: testbench/flow_through_burst_sram_access_tb.sv */
// Purpose: Self-checking bench for the flow-through burst SRAM access logic
// Assumes: Controller model drives pins at the falling edge
// Notes: Expected array contents live in a sparse model kept by the bench
`timescale 1ns/1ps
module flow_through_burst_sram_access_tb;
  localparam logic [2:0] SEL_ON = 3'h2;
  localparam logic [2:0] SEL_OFF = 3'h5;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic gate_n, adv_n, we_n, oe_n, order, dq_oe, wbuf_ready;
  logic [2:0] sel;
  logic [3:0] lane_n, par_out;
  logic [19:0] addr;
  logic [31:0] dq_out;
  logic [35:0] wd;
  logic [35:0] mem [logic [19:0]];
  logic [35:0] pend_d = 36'h000000000;
  logic pend_on = 1'h0;
  int fail_count = 0;
  int n_tests = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  sram_access u_dut (
    .I_SYS_CLK(sys_clk), .I_RESET(reset), .I_CLOCK_GATE_N(gate_n),
    .I_CHIP_SELECT_A_N(sel[2]), .I_CHIP_SELECT_B(sel[1]), .I_CHIP_SELECT_C_N(sel[0]),
    .I_ADVANCE_LOAD_N(adv_n), .I_WRITE_STROBE_N(we_n), .I_BYTE_LANE_WRITE_N(lane_n),
    .I_OUTPUT_DRIVE_EN_N(oe_n), .I_BURST_ORDER(order), .I_ADDR(addr),
    .I_DQ(wd[31:0]), .I_PARITY_PINS(wd[35:32]), .O_DQ(dq_out), .O_PARITY_PINS(par_out),
    .O_DQ_OE(dq_oe), .O_WBUF_READY(wbuf_ready)
  );

  sram_host_model u_host (
    .i_clk(sys_clk), .o_gate_n(gate_n), .o_sel(sel), .o_adv_n(adv_n), .o_we_n(we_n),
    .o_lane_n(lane_n), .o_oe_n(oe_n), .o_order(order), .o_addr(addr), .o_wd(wd)
  );

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Beat address: only the two low bits move, wrapping
  function automatic logic [19:0] beat(input logic [19:0] a, input logic ord,
                                       input logic [1:0] b);
    return {a[19:2], ord ? (a[1:0] ^ b) : (a[1:0] + b)};
  endfunction : beat

  // Unselected lanes keep their old byte and parity bit
  task automatic merge(input logic [19:0] a, input logic [35:0] d, input logic [3:0] ln);
    logic [35:0] w;
    w = mem.exists(a) ? mem[a] : 36'hXXXXXXXXX;
    for (int k = 0; k < 4; k++) begin
      if (!ln[k]) begin
        w[8*k +: 8] = d[8*k +: 8];
        w[32+k] = d[32+k];
      end
    end
    mem[a] = w;
  endtask : merge

  // Issue a command, carrying the data of the previous write beat
  task automatic op(input logic adv, input logic [2:0] s, input logic we, input logic [19:0] a,
                    input logic [3:0] ln, input logic wb, input logic [35:0] nd);
    u_host.cyc(adv, s, we, a, ln, pend_d, pend_on);
    pend_d = nd;
    pend_on = wb;
  endtask : op

  // Later beats show selects off and strobe high: the direction must stick
  task automatic wr_burst(input logic [19:0] a, input logic ord, input logic [35:0] d0,
                          input logic [3:0] ln);
    u_host.mode(1'h0, ord);
    for (int b = 0; b < 4; b++) begin
      merge(beat(a, ord, 2'(b)), d0 + 36'(b), ln);
      if (b == 0) op(1'h0, SEL_ON, 1'h0, a, ln, 1'h1, d0);
      else op(1'h1, SEL_OFF, 1'h1, ~a, ln, 1'h1, d0 + 36'(b));
      check(36'(dq_oe), 36'h0, "drive during write");
    end
  endtask : wr_burst

  // Later beats show a write strobe that must be ignored
  task automatic rd_burst(input logic [19:0] a, input logic ord, input logic oen, input int n);
    u_host.mode(oen, ord);
    for (int b = 0; b < n; b++) begin
      if (b == 0) op(1'h0, SEL_ON, 1'h1, a, 4'hF, 1'h0, 36'h0);
      else op(1'h1, SEL_OFF, 1'h0, ~a, 4'h0, 1'h0, 36'h0);
      if (!oen) check({par_out, dq_out}, mem[beat(a, ord, 2'(b))], "read data");
      check(36'(dq_oe), 36'(!oen), "drive during read");
    end
  endtask : rd_burst

  task automatic desel(input logic [2:0] s);
    op(1'h0, s, 1'h1, 20'h00000, 4'hF, 1'h0, 36'h0);
    check(36'(dq_oe), 36'h0, "drive after deselect");
  endtask : desel

  // Every start offset in both orders, read back in the other order past the wrap
  task automatic s_bursts;
    logic [19:0] a;
    for (int i = 0; i < 8; i++) begin
      a = {16'h1230 + 16'(i), 2'h0, 2'(i)};
      wr_burst(a, i[2], 36'h5A5A50000 + 36'(i * 16), 4'h0);
      rd_burst(a, !i[2], 1'h0, 5);
      desel(SEL_OFF);
    end
  endtask : s_bursts

  // Back-to-back write, partial write, read, write, read
  task automatic s_lanes;
    merge(20'h00F00, 36'h123456789, 4'h0);
    op(1'h0, SEL_ON, 1'h0, 20'h00F00, 4'h0, 1'h1, 36'h123456789);
    merge(20'h00F00, 36'hFEDCBA987, 4'hA);
    op(1'h0, SEL_ON, 1'h0, 20'h00F00, 4'hA, 1'h1, 36'hFEDCBA987);
    rd_burst(20'h00F00, 1'h0, 1'h0, 1);
    merge(20'h00F01, 36'h0C3C3C3C3, 4'h0);
    op(1'h0, SEL_ON, 1'h0, 20'h00F01, 4'h0, 1'h1, 36'h0C3C3C3C3);
    rd_burst(20'h00F01, 1'h0, 1'h0, 1);
    check(36'(wbuf_ready), 36'h0, "buffer full after read beat");
    desel(SEL_OFF);
    check(36'(wbuf_ready), 36'h1, "buffer room after drain");
  endtask : s_lanes

  // Suspended edges hold the read beat and the counter
  task automatic s_gate;
    wr_burst(20'h04440, 1'h1, 36'h900001111, 4'h0);
    rd_burst(20'h04440, 1'h1, 1'h0, 1);
    u_host.hold(3);
    check({par_out, dq_out}, mem[20'h04440], "gated data");
    check(36'(dq_oe), 36'h1, "gated drive");
    op(1'h1, SEL_OFF, 1'h1, 20'h00000, 4'hF, 1'h0, 36'h0);
    check({par_out, dq_out}, mem[20'h04441], "beat after gate");
    desel(SEL_OFF);
  endtask : s_gate

  // Each select alone deselects; advancing while deselected keeps pins off
  task automatic s_desel;
    logic [2:0] off [3] = '{3'h6, 3'h0, 3'h3};
    rd_burst(20'h04442, 1'h1, 1'h1, 2);
    foreach (off[k]) begin
      rd_burst(20'h04442, 1'h0, 1'h0, 1);
      desel(off[k]);
      op(1'h1, SEL_ON, 1'h1, 20'h04442, 4'hF, 1'h0, 36'h0);
      check(36'(dq_oe), 36'h0, "advance while deselected");
    end
  endtask : s_desel

  // Bounded run: a hang ends in the closing report
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    final_report();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    check({par_out, dq_out}, 36'h0, "reset data");
    check(36'(dq_oe), 36'h0, "reset drive");
    check(36'(wbuf_ready), 36'h1, "reset room");
    @(negedge sys_clk);
    reset = 1'h0;
    s_bursts();
    s_lanes();
    s_gate();
    s_desel();
    final_report();
  end
endmodule : flow_through_burst_sram_access_tb

/* File: testbench/sram_host_model.sv */
// Purpose: Memory controller model driving the SRAM pin bus
// Assumes: Pins change at the falling clock edge only
// Notes: Released data lines show the inverse of their last value; only a hold leaves a stale copy on them
`timescale 1ns/1ps
module sram_host_model (
  // Clock
  input wire logic i_clk,
  // Command pins, selects packed as {a_n, b, c_n}
  output logic o_gate_n,
  output logic [2:0] o_sel,
  output logic o_adv_n,
  output logic o_we_n,
  output logic [3:0] o_lane_n,
  output logic o_oe_n,
  output logic o_order,
  output logic [19:0] o_addr,
  // Write data, parity bits on top
  output logic [35:0] o_wd
);
  logic oe_nx = 1'h1;
  logic order_x = 1'h0;

  // Parked at time zero: open gate and a deselecting load
  initial begin
    o_gate_n = 1'h0;
    o_sel = 3'h5;
    o_adv_n = 1'h0;
    o_we_n = 1'h1;
    o_lane_n = 4'hF;
    o_oe_n = 1'h1;
    o_order = 1'h0;
    o_addr = 20'h00000;
    o_wd = 36'h000000000;
  end

  // Drive enable and strap go out with the next command
  task automatic mode(input logic oe_n, input logic ord);
    oe_nx = oe_n;
    order_x = ord;
  endtask : mode

  // One command cycle; data only in the cycle after a write beat
  task automatic cyc(input logic adv, input logic [2:0] sel, input logic we,
                     input logic [19:0] a, input logic [3:0] ln, input logic [35:0] wd,
                     input logic wd_on);
    @(negedge i_clk);
    o_gate_n = 1'h0;
    o_adv_n = adv;
    o_sel = sel;
    o_we_n = we;
    o_addr = a;
    o_lane_n = ln;
    o_oe_n = oe_nx;
    o_order = order_x;
    o_wd = wd_on ? wd : ~o_wd;
    @(posedge i_clk);
    #1;
  endtask : cyc

  // Suspend for n edges while showing a deselect that must be ignored
  task automatic hold(input int n);
    @(negedge i_clk);
    o_gate_n = 1'h1;
    o_adv_n = 1'h0;
    o_sel = 3'h5;
    repeat (n) @(posedge i_clk);
    #1;
  endtask : hold
endmodule : sram_host_model
